// >>> logic/wsd_pkg.sv
// Shared constants and types of the wheel speed and direction core.
// Assumes a 25 MHz core clock; pulse lengths are given in microseconds.
package wsd_pkg;
    localparam int SAMPLE_W = 12;
    localparam int SIG_W    = 14;
    localparam int CLK_MHZ  = 25;

    // Output pulse timing, microseconds
    localparam int PRE_LOW_US     = 40;
    localparam int SPEED_PULSE_US = 40;
    localparam int DIR_A_PULSE_US = 80;
    localparam int DIR_B_PULSE_US = 160;

    localparam int PRE_LOW_CYC     = PRE_LOW_US * CLK_MHZ;
    localparam int SPEED_PULSE_CYC = SPEED_PULSE_US * CLK_MHZ;
    localparam int DIR_A_PULSE_CYC = DIR_A_PULSE_US * CLK_MHZ;
    localparam int DIR_B_PULSE_CYC = DIR_B_PULSE_US * CLK_MHZ;
    localparam int PULSE_CNT_W     = 13;

    // Start-up figures
    localparam logic [SIG_W-1:0] SPEED_LIMIT_DEF   = 14'h0010;
    localparam logic [SIG_W-1:0] OFFSET_RST        = 14'h0000;
    localparam logic [1:0]       UNCAL_KEEP_PULSES = 2'h2;
    localparam int               HYST_SHIFT        = 3;
    localparam int               NOISE_SHIFT       = 2;

    typedef enum logic [1:0] {
        WSD_KIND_SPEED = 2'h0,
        WSD_KIND_DIR_A = 2'h1,
        WSD_KIND_DIR_B = 2'h2
    } wsd_kind_t;
endpackage

// >>> logic/wsd_pulse_if.sv
// Request path from the decision logic to the output pulse shaper.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface wsd_pulse_if;
    import wsd_pkg::*;
    logic      req;
    wsd_kind_t kind;
    logic      busy;
    modport ctl (output req, output kind, input busy);
    modport gen (input req, input kind, output busy);
endinterface
`default_nettype wire

// >>> logic/wsd_extrema.sv
// Slope tracker: finds turning points of a signal with a noise threshold.
// Assumes thr is positive and samples arrive with a one-cycle valid.
`timescale 1ns/1ps
`default_nettype none
module wsd_extrema #(
    parameter int W = 14
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clear,
    input  wire logic                restart,
    // Samples
    input  wire logic                valid,
    input  wire logic signed [W-1:0] x,
    input  wire logic        [W-1:0] thr,
    // Results
    output logic                     edge_rise,
    output logic                     edge_fall,
    output logic             [W-1:0] amp,
    output logic             [1:0]   ext_cnt,
    output logic signed      [W-1:0] mid
);
    logic                up, next_up;
    logic signed [W-1:0] run_pk, next_run_pk;
    logic signed [W-1:0] last_max, next_last_max;
    logic signed [W-1:0] last_min, next_last_min;
    logic        [1:0]   next_ext_cnt;
    logic                next_rise, next_fall;
    logic signed [W:0]   drop, rise;

    always_comb begin
        drop          = (W+1)'(run_pk) - (W+1)'(x);
        rise          = (W+1)'(x) - (W+1)'(run_pk);
        next_up       = up;
        next_run_pk   = run_pk;
        next_last_max = last_max;
        next_last_min = last_min;
        next_ext_cnt  = restart ? 2'h0 : ext_cnt;
        next_rise     = 1'b0;
        next_fall     = 1'b0;
        if (valid) begin
            if (up && x > run_pk) begin
                next_run_pk = x;
            end else if (up && drop > (W+1)'(thr)) begin
                next_last_max = run_pk;
                next_run_pk   = x;
                next_up       = 1'b0;
                next_fall     = 1'b1;
                if (next_ext_cnt != 2'h3) next_ext_cnt = next_ext_cnt + 2'h1;
            end else if (!up && x < run_pk) begin
                next_run_pk = x;
            end else if (!up && rise > (W+1)'(thr)) begin
                next_last_min = run_pk;
                next_run_pk   = x;
                next_up       = 1'b1;
                next_rise     = 1'b1;
                if (next_ext_cnt != 2'h3) next_ext_cnt = next_ext_cnt + 2'h1;
            end
        end
        if (clear) begin
            next_up       = 1'b0;
            next_run_pk   = '0;
            next_last_max = '0;
            next_last_min = '0;
            next_ext_cnt  = 2'h0;
            next_rise     = 1'b0;
            next_fall     = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up        <= 1'b0;
            run_pk    <= '0;
            last_max  <= '0;
            last_min  <= '0;
            ext_cnt   <= 2'h0;
            edge_rise <= 1'b0;
            edge_fall <= 1'b0;
        end else begin
            up        <= next_up;
            run_pk    <= next_run_pk;
            last_max  <= next_last_max;
            last_min  <= next_last_min;
            ext_cnt   <= next_ext_cnt;
            edge_rise <= next_rise;
            edge_fall <= next_fall;
        end
    end

    // Amplitude and midpoint of the last max/min pair
    assign amp = W'(last_max - last_min);
    assign mid = W'(((W+1)'(last_max) + (W+1)'(last_min)) >>> 1);
endmodule
`default_nettype wire

// >>> logic/wsd_pulse_gen.sv
// Output pulse shaper: pre-low interval, then a high-current pulse.
// Assumes requests arrive only while busy is low; others are dropped.
`timescale 1ns/1ps
`default_nettype none
module wsd_pulse_gen
    import wsd_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  clear,
    // Request port
    wsd_pulse_if.gen   p,
    // Pulse level
    output logic       high
);
    typedef enum logic [1:0] {
        WSD_PG_IDLE = 2'b00,
        WSD_PG_PRE  = 2'b01,
        WSD_PG_HIGH = 2'b11
    } wsd_pg_state_t;

    wsd_pg_state_t          state, next_state;
    logic [PULSE_CNT_W-1:0] cnt, next_cnt;
    logic [PULSE_CNT_W-1:0] len, next_len;
    logic                   next_high;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_len   = len;
        next_high  = 1'b0;
        case (state)
            WSD_PG_IDLE: begin
                if (p.req) begin
                    next_state = WSD_PG_PRE;
                    next_cnt   = PULSE_CNT_W'(PRE_LOW_CYC - 1);
                    case (p.kind) // see R21
                        WSD_KIND_DIR_A: next_len = PULSE_CNT_W'(DIR_A_PULSE_CYC - 1);
                        WSD_KIND_DIR_B: next_len = PULSE_CNT_W'(DIR_B_PULSE_CYC - 1);
                        default:        next_len = PULSE_CNT_W'(SPEED_PULSE_CYC - 1);
                    endcase
                end
            end
            WSD_PG_PRE: begin // see R16
                next_cnt = cnt - 1'b1;
                if (cnt == '0) begin
                    next_state = WSD_PG_HIGH;
                    next_cnt   = len;
                    next_high  = 1'b1;
                end
            end
            WSD_PG_HIGH: begin
                next_cnt  = cnt - 1'b1;
                next_high = 1'b1;
                if (cnt == '0) begin
                    next_state = WSD_PG_IDLE;
                    next_high  = 1'b0;
                end
            end
            default: next_state = WSD_PG_IDLE;
        endcase
        if (clear) begin
            next_state = WSD_PG_IDLE;
            next_high  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= WSD_PG_IDLE;
            cnt   <= '0;
            len   <= '0;
            high  <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            len   <= next_len;
            high  <= next_high;
        end
    end

    assign p.busy = (state != WSD_PG_IDLE);
endmodule
`default_nettype wire

// >>> logic/wsd_core.sv
// Digital core of a differential wheel speed and direction sensor.
// Assumes probe samples are synchronous to REF_CLK and strobed by SAMPLE_VALID.
// What this block does
// R1: First rising edge after power-on triggers pulse
// R2: Next rising edge triggers second pulse
// R3: Uncalibrated threshold follows amplitude, floor twice limit
// R4: Offset updates after two extrema, edge-matched
// R5: Offset updates independent of pulse generation
// R6: Successful correction enters calibrated hysteresis mode
// R7: Calibrated mode keeps adapting, adaptive hysteresis
// R8: Uncalibrated small signal: two pulses, third droppable
// R9: Excursions below hysteresis never switch output
// R10: Hysteresis is amplitude/8, floor at limit
// R11: Direction signal is centre minus outer mean
// R12: Direction sampled at speed zero crossing
// R13: First pulse carries speed only
// R14: Vibration identified and its pulse suppressed
// R15: Direction vibration check only after calibration
// R16: Pulse follows pre-low interval
// R17: Offset fed back to speed path DAC
// R18: Pulse protocol built from direction and vibration
// R19: Undervoltage after first pulse request forces high current
// R20: Deep undervoltage resets and restarts calibration
// R21: Pulse length encodes speed or direction
`timescale 1ns/1ps
`default_nettype none
module wsd_core #(
    parameter logic [wsd_pkg::SIG_W-1:0] SPEED_LIMIT = wsd_pkg::SPEED_LIMIT_DEF
) (
    // Clock and reset
    input  wire logic                                  REF_CLK,
    input  wire logic                                  RST_B,
    // Digitised probe samples
    input  wire logic signed [wsd_pkg::SAMPLE_W-1:0]   OUTER_PROBE_A,
    input  wire logic signed [wsd_pkg::SAMPLE_W-1:0]   OUTER_PROBE_B,
    input  wire logic signed [wsd_pkg::SAMPLE_W-1:0]   CENTRE_PROBE,
    input  wire logic                                  SAMPLE_VALID,
    // Supply monitor
    input  wire logic                                  UNDERVOLT,
    input  wire logic                                  DEEP_UNDERVOLT,
    // Current interface and status
    output logic                                       HIGH_CURRENT,
    output logic signed      [wsd_pkg::SIG_W-1:0]      OFFSET_DAC,
    output logic                                       CALIBRATED,
    output logic                                       DIRECTION_VALID,
    output logic                                       DIRECTION,
    output logic                                       VIBRATION
);
    import wsd_pkg::*;

    typedef enum logic {
        WSD_UNCAL = 1'b0,
        WSD_CAL   = 1'b1
    } wsd_mode_t;

    wsd_pulse_if pif ();

    // Analog-domain arithmetic done on the digitised probes
    logic signed [SIG_W-1:0] a_x, b_x, c_x;
    logic signed [SIG_W-1:0] speed_raw;
    logic signed [SIG_W-1:0] speed_cor;
    logic signed [SIG_W-1:0] dir_sig;

    assign a_x       = SIG_W'(OUTER_PROBE_A);
    assign b_x       = SIG_W'(OUTER_PROBE_B);
    assign c_x       = SIG_W'(CENTRE_PROBE);
    assign speed_raw = b_x - a_x;
    assign speed_cor = speed_raw - OFFSET_DAC; // see R17
    assign dir_sig   = c_x - SIG_W'((b_x + a_x) >>> 1); // see R11

    // Thresholds
    logic [SIG_W-1:0] amp;
    logic [SIG_W-1:0] noise_thr;
    logic [SIG_W-1:0] hyst;
    logic [SIG_W-1:0] two_limit;
    logic [SIG_W-1:0] amp_q, amp_e;

    assign two_limit = SIG_W'({SPEED_LIMIT, 1'b0});
    assign amp_q     = amp >> NOISE_SHIFT;
    assign amp_e     = amp >> HYST_SHIFT;
    // Slope threshold, never below twice the limit
    assign noise_thr = (amp_q > two_limit) ? amp_q : two_limit; // see R3, R7
    assign hyst      = (amp_e > SPEED_LIMIT) ? amp_e : SPEED_LIMIT; // see R10

    // Turning points of the corrected speed signal
    logic             trk_rise, trk_fall;
    logic [1:0]       ext_cnt;
    logic signed [SIG_W-1:0] mid;
    logic             upd;

    wsd_extrema #(
        .W (SIG_W)
    ) u_extrema (
        .clk       (REF_CLK),
        .rst_n     (RST_B),
        .clear     (DEEP_UNDERVOLT),
        .restart   (upd),
        .valid     (SAMPLE_VALID),
        .x         (speed_cor),
        .thr       (noise_thr),
        .edge_rise (trk_rise),
        .edge_fall (trk_fall),
        .amp       (amp),
        .ext_cnt   (ext_cnt),
        .mid       (mid)
    );

    logic pulse_high;

    wsd_pulse_gen u_pulse_gen (
        .clk   (REF_CLK),
        .rst_n (RST_B),
        .clear (DEEP_UNDERVOLT),
        .p     (pif.gen),
        .high  (pulse_high)
    );

    // Core state
    wsd_mode_t        mode, next_mode;
    logic signed [SIG_W-1:0] next_offset;
    logic             cmp_hi, next_cmp_hi;
    logic             prev_neg, next_prev_neg;
    logic             dir_lat, next_dir_lat;
    logic             next_dir_valid;
    logic             next_direction;
    logic             have_dir, next_have_dir;
    logic [1:0]       pulse_cnt, next_pulse_cnt;
    logic             uv_armed, next_uv_armed;
    logic             next_vib;
    logic             req, next_req;
    wsd_kind_t        req_kind, next_req_kind;
    logic             next_high_current;
    logic             rise_evt;
    logic             cmp_rise, cmp_fall;

    // Adaptive hysteresis comparator around zero once calibrated
    assign cmp_rise = SAMPLE_VALID && !cmp_hi && speed_cor > $signed(hyst); // see R9
    assign cmp_fall = SAMPLE_VALID && cmp_hi && speed_cor < -$signed(hyst); // see R9
    assign rise_evt = (mode == WSD_CAL) ? cmp_rise : trk_rise; // see R6, R7
    // Offset correction needs a fresh pair of extrema and a matching edge
    assign upd = (ext_cnt >= 2'h2) &&
                 ((trk_rise && mid >= 0) || (trk_fall && mid <= 0)); // see R4

    always_comb begin
        next_mode         = mode;
        next_offset       = OFFSET_DAC;
        next_cmp_hi       = cmp_hi;
        next_prev_neg     = prev_neg;
        next_dir_lat      = dir_lat;
        next_dir_valid    = DIRECTION_VALID;
        next_direction    = DIRECTION;
        next_have_dir     = have_dir;
        next_pulse_cnt    = pulse_cnt;
        next_uv_armed     = uv_armed;
        next_vib          = 1'b0;
        next_req          = 1'b0;
        next_req_kind     = req_kind;

        // Offset path runs on its own, untouched by pulse requests
        if (upd) begin
            next_offset = OFFSET_DAC + mid; // see R5, R17
            next_mode   = WSD_CAL; // see R6
        end

        if (cmp_rise) next_cmp_hi = 1'b1;
        if (cmp_fall) next_cmp_hi = 1'b0;

        // Centre probe sign caught where the speed signal crosses zero
        if (SAMPLE_VALID) begin
            next_prev_neg = speed_cor[SIG_W-1];
            if (speed_cor[SIG_W-1] != prev_neg) begin
                next_dir_lat   = dir_sig[SIG_W-1] ^ prev_neg; // see R12
                next_dir_valid = 1'b1;
            end
        end

        if (rise_evt) begin // see R1, R2
            next_req      = 1'b1;
            next_req_kind = WSD_KIND_SPEED;
            if (pulse_cnt != 2'h0 && mode == WSD_CAL && DIRECTION_VALID) begin // see R13
                next_req_kind  = dir_lat ? WSD_KIND_DIR_B : WSD_KIND_DIR_A; // see R18, R21
                next_direction = dir_lat;
                next_have_dir  = 1'b1;
                // A lone direction flip is taken as vibration
                if (have_dir && dir_lat != DIRECTION) begin // see R14, R15
                    next_req = 1'b0;
                    next_vib = 1'b1;
                end
            end
            if (mode == WSD_UNCAL && pulse_cnt >= UNCAL_KEEP_PULSES && amp < two_limit) begin
                next_req = 1'b0; // see R8
            end
            if (next_req && !pif.busy && pulse_cnt != 2'h3) next_pulse_cnt = pulse_cnt + 2'h1;
            if (next_req) next_uv_armed = 1'b1;
        end

        // Undervoltage holds the high current level after the first pulse request
        next_high_current = pulse_high || (UNDERVOLT && uv_armed); // see R16, R19

        if (DEEP_UNDERVOLT) begin // see R20
            next_mode         = WSD_UNCAL;
            next_offset       = OFFSET_RST;
            next_cmp_hi       = 1'b0;
            next_prev_neg     = 1'b0;
            next_dir_lat      = 1'b0;
            next_dir_valid    = 1'b0;
            next_direction    = 1'b0;
            next_have_dir     = 1'b0;
            next_pulse_cnt    = 2'h0;
            next_uv_armed     = 1'b0;
            next_vib          = 1'b0;
            next_req          = 1'b0;
            next_high_current = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode            <= WSD_UNCAL;
            OFFSET_DAC      <= OFFSET_RST;
            cmp_hi          <= 1'b0;
            prev_neg        <= 1'b0;
            dir_lat         <= 1'b0;
            DIRECTION_VALID <= 1'b0;
            DIRECTION       <= 1'b0;
            have_dir        <= 1'b0;
            pulse_cnt       <= 2'h0;
            uv_armed        <= 1'b0;
            VIBRATION       <= 1'b0;
            req             <= 1'b0;
            req_kind        <= WSD_KIND_SPEED;
            HIGH_CURRENT    <= 1'b0;
            CALIBRATED      <= 1'b0;
        end else begin
            mode            <= next_mode;
            OFFSET_DAC      <= next_offset;
            cmp_hi          <= next_cmp_hi;
            prev_neg        <= next_prev_neg;
            dir_lat         <= next_dir_lat;
            DIRECTION_VALID <= next_dir_valid;
            DIRECTION       <= next_direction;
            have_dir        <= next_have_dir;
            pulse_cnt       <= next_pulse_cnt;
            uv_armed        <= next_uv_armed;
            VIBRATION       <= next_vib;
            req             <= next_req;
            req_kind        <= next_req_kind;
            HIGH_CURRENT    <= next_high_current;
            CALIBRATED      <= (next_mode == WSD_CAL);
        end
    end

    // Requests that land while a pulse is running are lost by design
    assign pif.req  = req;
    assign pif.kind = req_kind;
endmodule
`default_nettype wire

// >>> sim/wsd_core_assertions.sv
// Port-level checks of the wheel speed and direction core.
// Assumes one clock domain; bound to every instance of the core.
`timescale 1ns/1ps
`default_nettype none
module wsd_core_chk
    import wsd_pkg::*;
(
    // Clock and reset
    input  wire logic                    REF_CLK,
    input  wire logic                    RST_B,
    // Supply
    input  wire logic                    UNDERVOLT,
    input  wire logic                    DEEP_UNDERVOLT,
    // Outputs of the core
    input  wire logic                    HIGH_CURRENT,
    input  wire logic signed [SIG_W-1:0] OFFSET_DAC,
    input  wire logic                    CALIBRATED,
    input  wire logic                    DIRECTION_VALID,
    input  wire logic                    DIRECTION,
    input  wire logic                    VIBRATION
);
    logic [PULSE_CNT_W-1:0] low_cnt, hi_cnt, next_low_cnt, next_hi_cnt;
    logic                   uv_mark, first, seen, next_uv_mark, next_first, next_seen;

    // Supply events mark a pulse as not shaped by the pulse generator
    always_comb begin
        next_hi_cnt  = HIGH_CURRENT ? hi_cnt + 1'b1 : '0;
        next_low_cnt = HIGH_CURRENT ? '0 : (&low_cnt ? low_cnt : low_cnt + 1'b1);
        next_uv_mark = UNDERVOLT | DEEP_UNDERVOLT | (uv_mark & HIGH_CURRENT);
        next_first   = DEEP_UNDERVOLT | (first & (HIGH_CURRENT | (hi_cnt == '0)));
        next_seen    = !DEEP_UNDERVOLT & (seen | (HIGH_CURRENT & !uv_mark));
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hi_cnt  <= '0;
            low_cnt <= '0;
            uv_mark <= 1'b0;
            first   <= 1'b1;
            seen    <= 1'b0;
        end else begin
            hi_cnt  <= next_hi_cnt;
            low_cnt <= next_low_cnt;
            uv_mark <= next_uv_mark;
            first   <= next_first;
            seen    <= next_seen;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    a_reset_quiet: assert property ($rose(RST_B) |-> !HIGH_CURRENT && !CALIBRATED && OFFSET_DAC == '0)
        else $error("outputs not idle after reset");
    a_deep_clear: assert property (DEEP_UNDERVOLT |=> !HIGH_CURRENT && !CALIBRATED && !DIRECTION_VALID
        && !VIBRATION && OFFSET_DAC == '0) else $error("deep undervoltage did not clear state");
    a_uv_hold: assert property (UNDERVOLT && seen && !DEEP_UNDERVOLT |=> HIGH_CURRENT)
        else $error("undervoltage did not force high current");
    a_pre_low: assert property ($rose(HIGH_CURRENT) && !uv_mark |-> low_cnt >= PRE_LOW_CYC)
        else $error("pulse rose without full pre-low interval");
    a_pulse_width: assert property ($fell(HIGH_CURRENT) && !uv_mark |-> hi_cnt == SPEED_PULSE_CYC
        || hi_cnt == DIR_A_PULSE_CYC || hi_cnt == DIR_B_PULSE_CYC) else $error("pulse length not a legal kind");
    a_first_speed: assert property ($fell(HIGH_CURRENT) && first && !uv_mark |-> hi_cnt == SPEED_PULSE_CYC)
        else $error("first pulse not a speed pulse");
    a_uncal_speed: assert property ($fell(HIGH_CURRENT) && !uv_mark && !CALIBRATED
        |-> hi_cnt == SPEED_PULSE_CYC) else $error("uncalibrated pulse carried direction");
    a_vib_cal: assert property (VIBRATION |-> (CALIBRATED && DIRECTION_VALID) ##1 !VIBRATION)
        else $error("vibration flag outside calibrated mode or too long");
    a_dac_cal: assert property ($changed(OFFSET_DAC) && !$past(DEEP_UNDERVOLT) |-> CALIBRATED)
        else $error("offset moved without calibrated mode");
    a_dir_keep: assert property (DIRECTION_VALID && !DEEP_UNDERVOLT |=> DIRECTION_VALID)
        else $error("direction result lost");

    c_cal: cover property ($rose(CALIBRATED));
    c_vib: cover property (VIBRATION);
    c_uv: cover property (UNDERVOLT && HIGH_CURRENT);
    c_dir_b: cover property ($fell(HIGH_CURRENT) && hi_cnt == DIR_B_PULSE_CYC);
endmodule

bind wsd_core wsd_core_chk wsd_core_chk_i (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .UNDERVOLT(UNDERVOLT), .DEEP_UNDERVOLT(DEEP_UNDERVOLT),
    .HIGH_CURRENT(HIGH_CURRENT), .OFFSET_DAC(OFFSET_DAC), .CALIBRATED(CALIBRATED),
    .DIRECTION_VALID(DIRECTION_VALID), .DIRECTION(DIRECTION), .VIBRATION(VIBRATION));
`default_nettype wire

// >>> sim/wsd_tcu.sv
// Control unit model: decodes high-current pulses on the two-wire line.
// Assumes the line level is sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none
module wsd_tcu (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Line level
    input  wire logic high,
    // Decoded pulses
    output var int    count,
    output var int    width
);
    int run;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run   <= 0;
            count <= 0;
            width <= 0;
        end else begin
            run <= high ? run + 1 : 0;
            // Length tells speed from either direction
            if (!high && run != 0) begin
                count <= count + 1;
                width <= run;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/test_wsd_core.sv
// Self-checking bench of the wheel speed and direction core.
// Assumes the core, its package and the control unit model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_wsd_core;
    import wsd_pkg::*;
    localparam int PER = 8000;

    logic                       REF_CLK = 1'b0;
    logic                       RST_B = 1'b0;
    logic signed [SAMPLE_W-1:0] OUTER_PROBE_A = '0;
    logic signed [SAMPLE_W-1:0] OUTER_PROBE_B = '0;
    logic signed [SAMPLE_W-1:0] CENTRE_PROBE = '0;
    logic                       SAMPLE_VALID = 1'b0;
    logic                       UNDERVOLT = 1'b0;
    logic                       DEEP_UNDERVOLT = 1'b0;
    logic                       HIGH_CURRENT, CALIBRATED, DIRECTION_VALID, DIRECTION, VIBRATION;
    logic signed [SIG_W-1:0]    OFFSET_DAC;
    int failures = 0, tests_run = 0, n = 0, mode = 0, fwd = 1, vib_cnt = 0, tcu_cnt, tcu_w;

    wsd_core #(.SPEED_LIMIT(SPEED_LIMIT_DEF)) wsd_core_i (
        .REF_CLK(REF_CLK), .RST_B(RST_B), .OUTER_PROBE_A(OUTER_PROBE_A), .OUTER_PROBE_B(OUTER_PROBE_B),
        .CENTRE_PROBE(CENTRE_PROBE), .SAMPLE_VALID(SAMPLE_VALID), .UNDERVOLT(UNDERVOLT),
        .DEEP_UNDERVOLT(DEEP_UNDERVOLT), .HIGH_CURRENT(HIGH_CURRENT), .OFFSET_DAC(OFFSET_DAC),
        .CALIBRATED(CALIBRATED), .DIRECTION_VALID(DIRECTION_VALID), .DIRECTION(DIRECTION),
        .VIBRATION(VIBRATION));
    wsd_tcu wsd_tcu_i (.clk(REF_CLK), .rst_n(RST_B), .high(HIGH_CURRENT), .count(tcu_cnt), .width(tcu_w));

    always #20 REF_CLK = ~REF_CLK;

    // Triangle of +-400; outer probes in antiphase, centre a quarter off
    function automatic int wave_at(input int p);
        p = ((p % PER) + PER) % PER;
        return (p < PER / 2) ? (p / 5 - 400) : (1200 - p / 5);
    endfunction

    // Offset of 40 on one probe so calibration has work to do
    always @(negedge REF_CLK) begin
        if (mode == 1) begin
            OUTER_PROBE_A <= SAMPLE_W'(-wave_at(n));
            OUTER_PROBE_B <= SAMPLE_W'(wave_at(n) + 40);
            CENTRE_PROBE  <= SAMPLE_W'(wave_at(n + fwd * PER / 4));
        end else begin
            OUTER_PROBE_A <= '0;
            OUTER_PROBE_B <= SAMPLE_W'(((n / 100) % 2) ? 90 : -10);
            CENTRE_PROBE  <= '0;
        end
        SAMPLE_VALID <= (mode != 0) && (n % 8 != 7);
        if (mode != 0) n++;
    end

    always @(negedge REF_CLK) if (VIBRATION === 1'b1) vib_cnt++;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_pulse(input int lim);
        int c0;
        c0 = tcu_cnt;
        repeat (lim) begin
            @(negedge REF_CLK);
            if (tcu_cnt != c0) return;
        end
        check("pulse arrival", 1'b0, 1'b1);
    endtask

    task automatic run_to(input int target);
        while (n < target) @(negedge REF_CLK);
    endtask

    task automatic start_wave(input int dir, input int m, input bit restart);
        @(posedge REF_CLK);
        fwd = dir;
        mode = m;
        if (restart) n = 0;
    endtask

    task automatic test_startup();
        start_wave(1, 1, 1);
        wait_pulse(PER * 2);
        check("first width", tcu_w, SPEED_PULSE_CYC);
        wait_pulse(PER * 2);
        check("second pulse", tcu_cnt, 2);
        run_to(PER * 5);
        check("calibrated", CALIBRATED, 1'b1);
        check("offset", OFFSET_DAC, 32'h0000_0028);
        check("dir valid", DIRECTION_VALID, 1'b1);
        check("direction", DIRECTION, 1'b1);
        check("dir width", tcu_w, DIR_B_PULSE_CYC);
    endtask

    task automatic test_reverse();
        start_wave(-1, 1, 0);
        run_to(PER * 7);
        check("vibration seen", vib_cnt != 0, 1'b1);
        check("direction", DIRECTION, 1'b0);
        check("dir width", tcu_w, DIR_A_PULSE_CYC);
    endtask

    task automatic test_wiggle();
        int c0;
        start_wave(1, 2, 0);
        c0 = tcu_cnt;
        repeat (3000) @(negedge REF_CLK);
        check("wiggle pulses", tcu_cnt, c0);
    endtask

    task automatic test_supply();
        start_wave(1, 0, 0);
        @(negedge REF_CLK);
        UNDERVOLT = 1'b1;
        @(negedge REF_CLK);
        check("undervolt hold", HIGH_CURRENT, 1'b1);
        repeat (4) @(negedge REF_CLK);
        UNDERVOLT = 1'b0;
        repeat (3) @(negedge REF_CLK);
        check("supply back", HIGH_CURRENT, 1'b0);
        DEEP_UNDERVOLT = 1'b1;
        @(negedge REF_CLK);
        DEEP_UNDERVOLT = 1'b0;
        check("deep flags", {HIGH_CURRENT, CALIBRATED, DIRECTION_VALID, DIRECTION, VIBRATION}, 5'h00);
        check("deep offset", OFFSET_DAC, 32'h0000_0000);
        UNDERVOLT = 1'b1;
        repeat (2) @(negedge REF_CLK);
        check("undervolt before pulse", HIGH_CURRENT, 1'b0);
        UNDERVOLT = 1'b0;
    endtask

    task automatic test_restart();
        start_wave(1, 1, 1);
        wait_pulse(PER * 2);
        check("restart width", tcu_w, SPEED_PULSE_CYC);
    endtask

    initial begin
        repeat (20) @(negedge REF_CLK);
        RST_B = 1'b1;
        test_startup();
        test_reverse();
        test_wiggle();
        test_supply();
        test_restart();
        finish_test();
    end

    // Expected run is about 61000 cycles
    initial begin
        repeat (95000) @(posedge REF_CLK);
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
